/* common/tmw_pkg.sv */
// constants and types for the 8-bit waveform timer
// assumes a 32-bit classic wishbone slave with byte addresses
package tmw_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] TMW_ADR_CTRL = 8'h00;
  localparam logic [7:0] TMW_ADR_COUNT = 8'h04;
  localparam logic [7:0] TMW_ADR_COMPARE = 8'h08;
  localparam logic [7:0] TMW_ADR_STATUS = 8'h0C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned TMW_CTRL_MODE_LSB = 0;
  localparam int unsigned TMW_CTRL_ACT_LSB = 2;
  localparam int unsigned TMW_CTRL_CS_LSB = 4;
  localparam int unsigned TMW_CTRL_ASYNC_BIT = 7;
  localparam int unsigned TMW_CTRL_DIR_BIT = 8;
  localparam int unsigned TMW_CTRL_FORCE_BIT = 9;
  localparam int unsigned TMW_STAT_OVF_BIT = 0;
  localparam int unsigned TMW_STAT_CMP_BIT = 1;
  localparam int unsigned TMW_STAT_OC_BIT = 2;

  // ----------------------------------------------------------------
  // modes and actions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMW_MODE_NORMAL = 2'h0,
    TMW_MODE_PHASE = 2'h1,
    TMW_MODE_CLEAR = 2'h2,
    TMW_MODE_FAST = 2'h3
  } tmw_mode_type;

  localparam logic [1:0] TMW_ACT_OFF = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMW_ACT_SET = 2'h3;

  // count direction, one-hot
  typedef enum logic [1:0] {
    TMW_DIR_UP = 2'b01,
    TMW_DIR_DOWN = 2'b10
  } tmw_dir_type;

  // ----------------------------------------------------------------
  // clock select codes and prescaler masks
  // ----------------------------------------------------------------
  localparam logic [2:0] TMW_CS_STOP = 3'h0;
  localparam logic [2:0] TMW_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMW_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMW_CS_DIV32 = 3'h3;
  localparam logic [2:0] TMW_CS_DIV64 = 3'h4;
  localparam logic [2:0] TMW_CS_DIV128 = 3'h5;
  localparam logic [2:0] TMW_CS_DIV256 = 3'h6;
  localparam logic [2:0] TMW_CS_DIV1024 = 3'h7;
  localparam logic [9:0] TMW_MASK_DIV1 = 10'h000;
  localparam logic [9:0] TMW_MASK_DIV8 = 10'h007;
  localparam logic [9:0] TMW_MASK_DIV32 = 10'h01F;
  localparam logic [9:0] TMW_MASK_DIV64 = 10'h03F;
  localparam logic [9:0] TMW_MASK_DIV128 = 10'h07F;
  localparam logic [9:0] TMW_MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] TMW_MASK_DIV1024 = 10'h3FF;

  // ----------------------------------------------------------------
  // count values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  localparam logic [7:0] TMW_BOTTOM_P1 = 8'h01;
  localparam logic [7:0] TMW_MAX = 8'hFF;
  localparam logic [7:0] TMW_MAX_M1 = 8'hFE;
  localparam logic [7:0] TMW_ONE = 8'h01;
  localparam logic [9:0] TMW_PRESC_ONE = 10'h001;

endpackage

/* logic/tmw_timer8.sv */
// 8-bit timer with one compare channel: normal, clear-on-match,
// fast pwm and phase-correct pwm, behind a classic wishbone slave.
// assumes one 40 MHz clock; the timer oscillator arrives as a pin
// and is sampled, never used as a clock.
`timescale 1ns/1ps

module tmw_timer8 (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_OSC_CLK,
  output logic O_COMPARE_OUTPUT,
  output logic O_COMPARE_OUTPUT_OE
);
  import tmw_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    tmw_mode_type waveform_mode_select;
    logic [1:0] compare_output_action;
    logic [2:0] clock_select;
    logic async_select;
    logic pin_direction_out;
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    tmw_dir_type dir;
    logic match_block;
    logic overflow_flag;
    logic compare_match_flag;
    logic compare_output;
    logic [9:0] presc;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic pin_value;
    logic pin_oe;
  } tmw_state_type;

  localparam tmw_state_type TMW_STATE_RST = '{
    ack: 1'b0,
    dat: 32'h0000_0000,
    waveform_mode_select: TMW_MODE_NORMAL,
    compare_output_action: TMW_ACT_OFF,
    clock_select: TMW_CS_STOP,
    async_select: 1'b0,
    pin_direction_out: 1'b0,
    counter_value: TMW_BOTTOM,
    compare_value: TMW_BOTTOM,
    compare_buffer: TMW_BOTTOM,
    dir: TMW_DIR_UP,
    match_block: 1'b0,
    overflow_flag: 1'b0,
    compare_match_flag: 1'b0,
    compare_output: 1'b0,
    presc: 10'h000,
    osc_s1: 1'b0,
    osc_s2: 1'b0,
    osc_s3: 1'b0,
    pin_value: 1'b0,
    pin_oe: 1'b0
  };

  tmw_state_type s_r;
  tmw_state_type s_nxt;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic acc;
    logic wr;
    logic base;
    logic run;
    logic tick;
    logic pwm;
    logic match;
    logic force_hit;
    logic [9:0] mask;
    logic [1:0] act;
    tmw_dir_type dir_n;
    acc = 1'b0;
    wr = 1'b0;
    base = 1'b0;
    run = 1'b0;
    tick = 1'b0;
    pwm = 1'b0;
    match = 1'b0;
    force_hit = 1'b0;
    mask = TMW_MASK_DIV1;
    act = TMW_ACT_OFF;
    dir_n = TMW_DIR_UP;
    s_nxt = s_r;

    // oscillator pin: two flops, then edge detect on the second
    s_nxt.osc_s1 = I_OSC_CLK;
    s_nxt.osc_s2 = s_r.osc_s1;
    s_nxt.osc_s3 = s_r.osc_s2;

    // ----------------------------------------------------------------
    // timer clock enable
    // ----------------------------------------------------------------
    // oscillator edges stand in for the io clock in async mode;
    // the oscillator must run well below a quarter of the core clock
    base = s_r.async_select ? (s_r.osc_s2 & ~s_r.osc_s3) : 1'b1;
    unique case (s_r.clock_select)
      TMW_CS_DIV8: mask = TMW_MASK_DIV8;
      TMW_CS_DIV32: mask = TMW_MASK_DIV32;
      TMW_CS_DIV64: mask = TMW_MASK_DIV64;
      TMW_CS_DIV128: mask = TMW_MASK_DIV128;
      TMW_CS_DIV256: mask = TMW_MASK_DIV256;
      TMW_CS_DIV1024: mask = TMW_MASK_DIV1024;
      TMW_CS_STOP,
      TMW_CS_DIV1: mask = TMW_MASK_DIV1;
    endcase
    run = (s_r.clock_select != TMW_CS_STOP);
    if (base && run) begin
      s_nxt.presc = s_r.presc + TMW_PRESC_ONE;
    end
    tick = base && run && ((s_r.presc & mask) == mask);

    pwm = (s_r.waveform_mode_select == TMW_MODE_PHASE) ||
          (s_r.waveform_mode_select == TMW_MODE_FAST);
    // a count write suppresses the match seen at the next tick
    match = (s_r.counter_value == s_r.compare_value) && !s_r.match_block;
    act = s_r.compare_output_action;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    acc = I_WB_CYC && I_WB_STB && !s_r.ack;
    wr = acc && I_WB_WE;
    s_nxt.ack = acc;
    s_nxt.dat = 32'h0000_0000;
    if (acc && !I_WB_WE) begin
      unique case (I_WB_ADR)
        TMW_ADR_CTRL: begin
          s_nxt.dat[TMW_CTRL_MODE_LSB +: 2] = s_r.waveform_mode_select;
          s_nxt.dat[TMW_CTRL_ACT_LSB +: 2] = s_r.compare_output_action;
          s_nxt.dat[TMW_CTRL_CS_LSB +: 3] = s_r.clock_select;
          s_nxt.dat[TMW_CTRL_ASYNC_BIT] = s_r.async_select;
          s_nxt.dat[TMW_CTRL_DIR_BIT] = s_r.pin_direction_out;
        end
        TMW_ADR_COUNT: s_nxt.dat[7:0] = s_r.counter_value;
        TMW_ADR_COMPARE: s_nxt.dat[7:0] = s_r.compare_buffer;
        TMW_ADR_STATUS: begin
          s_nxt.dat[TMW_STAT_OVF_BIT] = s_r.overflow_flag;
          s_nxt.dat[TMW_STAT_CMP_BIT] = s_r.compare_match_flag;
          s_nxt.dat[TMW_STAT_OC_BIT] = s_r.compare_output;
        end
        default: s_nxt.dat = 32'h0000_0000;
      endcase
    end

    // write-one-to-clear; a set on the same tick below wins
    if (wr && I_WB_SEL[0] && (I_WB_ADR == TMW_ADR_STATUS)) begin
      if (I_WB_DAT[TMW_STAT_OVF_BIT]) begin
        s_nxt.overflow_flag = 1'b0;
      end
      if (I_WB_DAT[TMW_STAT_CMP_BIT]) begin
        s_nxt.compare_match_flag = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // counting, flags and waveform
    // ----------------------------------------------------------------
    if (tick) begin
      s_nxt.match_block = 1'b0;
      if (match) begin
        s_nxt.compare_match_flag = 1'b1;
      end
      unique case (s_r.waveform_mode_select)
        TMW_MODE_NORMAL: begin
          s_nxt.dir = TMW_DIR_UP;
          s_nxt.counter_value = s_r.counter_value + TMW_ONE;
          if (s_r.counter_value == TMW_MAX) begin
            s_nxt.overflow_flag = 1'b1;
          end
        end
        TMW_MODE_CLEAR: begin
          s_nxt.dir = TMW_DIR_UP;
          // unbuffered top: a top below the count is passed and the
          // count wraps through max before it can match
          if (match) begin
            s_nxt.counter_value = TMW_BOTTOM;
          end else begin
            s_nxt.counter_value = s_r.counter_value + TMW_ONE;
          end
          if (s_r.counter_value == TMW_MAX) begin
            s_nxt.overflow_flag = 1'b1;
          end
        end
        TMW_MODE_FAST: begin
          s_nxt.dir = TMW_DIR_UP;
          if (s_r.counter_value == TMW_MAX) begin
            s_nxt.counter_value = TMW_BOTTOM;
            s_nxt.compare_value = s_r.compare_buffer;
          end else begin
            s_nxt.counter_value = s_r.counter_value + TMW_ONE;
          end
          if (s_r.counter_value == TMW_MAX_M1) begin
            s_nxt.overflow_flag = 1'b1;
          end
        end
        TMW_MODE_PHASE: begin
          unique case (s_r.dir)
            TMW_DIR_UP: begin
              dir_n = (s_r.counter_value == TMW_MAX) ? TMW_DIR_DOWN : TMW_DIR_UP;
            end
            TMW_DIR_DOWN: begin
              dir_n = (s_r.counter_value == TMW_BOTTOM) ? TMW_DIR_UP : TMW_DIR_DOWN;
            end
            default: dir_n = TMW_DIR_UP;
          endcase
          s_nxt.dir = dir_n;
          // max and bottom each held for one tick: 510 per period
          if (dir_n == TMW_DIR_UP) begin
            s_nxt.counter_value = s_r.counter_value + TMW_ONE;
          end else begin
            s_nxt.counter_value = s_r.counter_value - TMW_ONE;
          end
          if (s_r.counter_value == TMW_MAX) begin
            s_nxt.compare_value = s_r.compare_buffer;
          end
          if ((dir_n == TMW_DIR_DOWN) && (s_r.counter_value == TMW_BOTTOM_P1)) begin
            s_nxt.overflow_flag = 1'b1;
          end
        end
      endcase

      // output on match; direction is that of the step taken, so a
      // compare at bottom or max leaves a constant level
      if (match) begin
        unique case (s_r.waveform_mode_select)
          TMW_MODE_PHASE: begin
            if (act == TMW_ACT_CLEAR) begin
              s_nxt.compare_output = (dir_n == TMW_DIR_DOWN);
            end else if (act == TMW_ACT_SET) begin
              s_nxt.compare_output = (dir_n == TMW_DIR_UP);
            end
          end
          TMW_MODE_FAST: begin
            if (act == TMW_ACT_TOGGLE) begin
              s_nxt.compare_output = ~s_r.compare_output;
            end else if (act == TMW_ACT_CLEAR) begin
              s_nxt.compare_output = 1'b0;
            end else if (act == TMW_ACT_SET) begin
              s_nxt.compare_output = 1'b1;
            end
          end
          TMW_MODE_NORMAL,
          TMW_MODE_CLEAR: begin
            if (act == TMW_ACT_TOGGLE) begin
              s_nxt.compare_output = ~s_r.compare_output;
            end else if (act == TMW_ACT_CLEAR) begin
              s_nxt.compare_output = 1'b0;
            end else if (act == TMW_ACT_SET) begin
              s_nxt.compare_output = 1'b1;
            end
          end
        endcase
      end

      // bottom action overrides a match on the same tick, which makes
      // compare = max a constant level and compare = 0 a one-tick spike
      if ((s_r.waveform_mode_select == TMW_MODE_FAST) &&
          (s_r.counter_value == TMW_MAX)) begin
        if (act == TMW_ACT_CLEAR) begin
          s_nxt.compare_output = 1'b1;
        end else if (act == TMW_ACT_SET) begin
          s_nxt.compare_output = 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr && (I_WB_ADR == TMW_ADR_CTRL)) begin
      if (I_WB_SEL[0]) begin
        s_nxt.waveform_mode_select =
          tmw_mode_type'(I_WB_DAT[TMW_CTRL_MODE_LSB +: 2]);
        s_nxt.compare_output_action = I_WB_DAT[TMW_CTRL_ACT_LSB +: 2];
        s_nxt.clock_select = I_WB_DAT[TMW_CTRL_CS_LSB +: 3];
        s_nxt.async_select = I_WB_DAT[TMW_CTRL_ASYNC_BIT];
      end
      if (I_WB_SEL[1]) begin
        s_nxt.pin_direction_out = I_WB_DAT[TMW_CTRL_DIR_BIT];
        // forced compare: no flag, no clear, non-pwm modes only
        force_hit = I_WB_DAT[TMW_CTRL_FORCE_BIT] && !pwm;
      end
    end
    if (force_hit) begin
      unique case (s_nxt.compare_output_action)
        TMW_ACT_TOGGLE: s_nxt.compare_output = ~s_r.compare_output;
        TMW_ACT_CLEAR: s_nxt.compare_output = 1'b0;
        TMW_ACT_SET: s_nxt.compare_output = 1'b1;
        TMW_ACT_OFF: s_nxt.compare_output = s_r.compare_output;
      endcase
    end

    // a count write wins over the tick and blocks the next match
    if (wr && I_WB_SEL[0] && (I_WB_ADR == TMW_ADR_COUNT)) begin
      s_nxt.counter_value = I_WB_DAT[7:0];
      s_nxt.match_block = 1'b1;
    end

    if (wr && I_WB_SEL[0] && (I_WB_ADR == TMW_ADR_COMPARE)) begin
      s_nxt.compare_buffer = I_WB_DAT[7:0];
      if (!pwm) begin
        s_nxt.compare_value = I_WB_DAT[7:0];
      end
    end

    // ----------------------------------------------------------------
    // pin
    // ----------------------------------------------------------------
    // action 0 hands the pin back to the port; direction gates the driver
    s_nxt.pin_oe = s_nxt.pin_direction_out &&
                   (s_nxt.compare_output_action != TMW_ACT_OFF);
    s_nxt.pin_value = s_nxt.pin_oe && s_nxt.compare_output;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      s_r <= TMW_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_WB_ACK = s_r.ack;
  assign O_WB_DAT = s_r.dat;
  assign O_COMPARE_OUTPUT = s_r.pin_value;
  assign O_COMPARE_OUTPUT_OE = s_r.pin_oe;

endmodule

/* tb/tmw_checker.sv */
// checker for the waveform timer: bus handshake and pin rules
// assumes it is bound to tmw_timer8 and sees only its ports
`timescale 1ns/1ps

module tmw_checker (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic I_OSC_CLK,
  input wire logic O_COMPARE_OUTPUT,
  input wire logic O_COMPARE_OUTPUT_OE
);
  import tmw_pkg::*;
  // ----------------------------------------------------------------
  // shadow of the control word, rebuilt from bus writes
  // ----------------------------------------------------------------
  logic [9:0] ctrl_r;
  logic tk;
  logic wr;
  assign tk = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr = tk && I_WB_WE && I_WB_ADR == TMW_ADR_CTRL;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      ctrl_r <= 10'h000;
    end else if (wr) begin
      if (I_WB_SEL[0]) ctrl_r[7:0] <= I_WB_DAT[7:0];
      if (I_WB_SEL[1]) ctrl_r[8] <= I_WB_DAT[8];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  sequence s_req;
    tk;
  endsequence
  sequence s_answer;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  property p_ack_pulse;
    s_req |=> s_answer;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack is not a single pulse");
  property p_ack_cause;
    O_WB_ACK |-> $past(tk);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
  property p_dat_idle;
    !O_WB_ACK |-> O_WB_DAT == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
  property p_unmapped;
    tk && !I_WB_WE && (I_WB_ADR > TMW_ADR_STATUS || I_WB_ADR[1:0] != 2'h0)
      |=> O_WB_DAT == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pin_zero;
    !O_COMPARE_OUTPUT_OE |-> !O_COMPARE_OUTPUT;
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("pin driven while disabled");
  // two cycles on: control register and registered enable both update one cycle after the write
  property p_oe_dir;
    wr |-> ##2 (O_COMPARE_OUTPUT_OE == (ctrl_r[8] && ctrl_r[3:2] != TMW_ACT_OFF));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin enable wrong");
  property p_reset_quiet;
    $rose(I_RSTN) |-> !O_WB_ACK && !O_COMPARE_OUTPUT_OE;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_hold_stop;
    ctrl_r[6:4] == TMW_CS_STOP && !tk && !$past(tk) && !$past(tk, 2)
      |-> $stable(O_COMPARE_OUTPUT);
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("pin moved while stopped");
endmodule

bind tmw_timer8 tmw_checker tmw_checker_inst (
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_OSC_CLK(I_OSC_CLK),
  .O_COMPARE_OUTPUT(O_COMPARE_OUTPUT), .O_COMPARE_OUTPUT_OE(O_COMPARE_OUTPUT_OE));

/* tb/test_tmw_timer8.sv */
// self-checking bench for the waveform timer
// assumes the checker is bound in; pin behaviour is judged by timing
`timescale 1ns/1ps

module test_tmw_timer8;
  import tmw_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic osc = 1'b0;
  logic osc_on = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h3;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic ack;
  logic pin;
  logic oe;
  int bad_count = 0;
  int checks = 0;
  int seed = 42438;
  int osc_cnt = 0;
  int n;
  int h;
  int w;
  int e;
  logic [1:0] md;
  logic [1:0] ac;
  logic [7:0] cv;

  tmw_timer8 tmw_timer8_inst (
    .I_REF_CLK(ref_clk), .I_RSTN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(dat_o), .O_WB_ACK(ack),
    .I_OSC_CLK(osc), .O_COMPARE_OUTPUT(pin), .O_COMPARE_OUTPUT_OE(oe));

  always #12.5 ref_clk = ~ref_clk;
  // oscillator of twelve clocks, well under a quarter of the clock rate
  always @(posedge ref_clk) begin
    if (osc_on) begin
      osc_cnt <= (osc_cnt == 5) ? 0 : osc_cnt + 1;
      if (osc_cnt == 5) osc <= ~osc;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fail_wait();
    bad_count++;
    $display("mismatch at %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic wb(input logic w_i, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_i;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) fail_wait();
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask
  task automatic ctl(input logic [1:0] m, input logic [1:0] a, input logic [2:0] c,
                     input logic asy, input logic frc);
    wb(1'b1, TMW_ADR_CTRL, {22'h0, frc, 1'b1, asy, c, a, m});
  endtask
  task automatic wait_change(output int k);
    logic p;
    p = pin;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pin === p && k < 9000);
    if (pin === p) fail_wait();
  endtask
  // the first change may come from a partial period, so it is skipped
  task automatic measure(output int k);
    wait_change(k);
    wait_change(k);
  endtask
  task automatic high(input int win, output int k);
    k = 0;
    repeat (win) begin
      @(posedge ref_clk);
      if (pin === 1'b1) k++;
    end
  endtask
  task automatic ctc_setup(input logic [7:0] cnt, input logic [7:0] cmp);
    ctl(TMW_MODE_CLEAR, TMW_ACT_TOGGLE, TMW_CS_STOP, 1'b0, 1'b0);
    wb(1'b1, TMW_ADR_STATUS, 32'h0000_0003);
    wb(1'b1, TMW_ADR_COUNT, {24'h0, cnt});
    wb(1'b1, TMW_ADR_COMPARE, {24'h0, cmp});
  endtask
  function automatic int div_of(input int c);
    case (c)
      1: return 1;
      2: return 8;
      3: return 32;
      4: return 64;
      5: return 128;
      6: return 256;
      default: return 1024;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(TMW_ADR_CTRL, 32'h0000_0000);
    rd(TMW_ADR_COUNT, 32'h0000_0000);
    rd(TMW_ADR_COMPARE, 32'h0000_0000);
    rd(TMW_ADR_STATUS, 32'h0000_0000);
    wb(1'b1, 8'h10, 32'h0000_00FF);
    rd(8'h10, 32'h0000_0000);
    rd(TMW_ADR_CTRL, 32'h0000_0000);
    ctl(TMW_MODE_NORMAL, TMW_ACT_SET, TMW_CS_STOP, 1'b0, 1'b1);
    repeat (3) @(posedge ref_clk);
    check(pin, 1'b1);
    ctl(TMW_MODE_NORMAL, TMW_ACT_OFF, TMW_CS_STOP, 1'b0, 1'b0);
    ctc_setup(8'h00, 8'h00);
    ctl(TMW_MODE_CLEAR, TMW_ACT_OFF, TMW_CS_DIV1, 1'b0, 1'b0);
    repeat (20) @(posedge ref_clk);
    wb(1'b0, TMW_ADR_STATUS, 32'h0000_0000);
    check(rdat[2], 1'b1);
    check(oe, 1'b0);
    for (int c = 1; c < 8; c++) begin
      // compare 0 against a blocked count of 0 needs a full wrap first,
      // far too long at the slow dividers
      cv = (c == 1) ? 8'h00 : 8'($unsigned($random(seed)) % 4 + 1);
      ctc_setup(8'h00, cv);
      ctl(TMW_MODE_CLEAR, TMW_ACT_TOGGLE, 3'(c), 1'b0, 1'b0);
      measure(n);
      check(n, div_of(c) * (cv + 1));
    end
    ctc_setup(8'd100, 8'd50);
    ctl(TMW_MODE_CLEAR, TMW_ACT_TOGGLE, TMW_CS_DIV1, 1'b0, 1'b0);
    wait_change(n);
    check(n >= 200 && n <= 215, 1'b1);
    wb(1'b0, TMW_ADR_STATUS, 32'h0000_0000);
    check(rdat[1:0], 2'b11);
    wb(1'b1, TMW_ADR_STATUS, 32'h0000_0003);
    wb(1'b0, TMW_ADR_STATUS, 32'h0000_0000);
    check(rdat[1:0], 2'b00);
    for (int k = 0; k < 12; k++) begin
      md = (k % 2 == 1) ? TMW_MODE_PHASE : TMW_MODE_FAST;
      ac = (k % 4 >= 2) ? TMW_ACT_SET : TMW_ACT_CLEAR;
      cv = (k < 4) ? TMW_BOTTOM : (k < 8) ? TMW_MAX : 8'($unsigned($random(seed)) % 254 + 1);
      wb(1'b1, TMW_ADR_COMPARE, {24'h0, cv});
      ctl(md, ac, TMW_CS_DIV1, 1'b0, 1'b0);
      wb(1'b1, TMW_ADR_STATUS, 32'h0000_0003);
      repeat (600) @(posedge ref_clk);
      w = (md == TMW_MODE_FAST) ? 512 : 1020;
      e = (md == TMW_MODE_FAST) ? 2 * (cv + 1) : 4 * cv;
      if (ac == TMW_ACT_SET) e = w - e;
      high(w, h);
      check(h, e);
      wb(1'b0, TMW_ADR_STATUS, 32'h0000_0000);
      check(rdat[0], 1'b1);
    end
    wb(1'b1, TMW_ADR_COMPARE, 32'h0000_0000);
    ctl(TMW_MODE_FAST, TMW_ACT_TOGGLE, TMW_CS_DIV1, 1'b0, 1'b0);
    // the old compare may still match once before the buffer loads at max
    wait_change(n);
    measure(n);
    check(n, 256);
    ctc_setup(8'h00, 8'h00);
    ctl(TMW_MODE_NORMAL, TMW_ACT_TOGGLE, TMW_CS_DIV1, 1'b0, 1'b0);
    measure(n);
    check(n, 256);
    ctc_setup(8'h00, 8'h00);
    osc_on <= 1'b1;
    ctl(TMW_MODE_CLEAR, TMW_ACT_TOGGLE, TMW_CS_DIV1, 1'b1, 1'b0);
    measure(n);
    check(n, 12);
    finish_test();
  end
endmodule
